// file: hw/pllcm_top.sv
// pll clock module control: ratio, bypass, lock, low-power entry, registers
// What this block does
// - a 4-bit ratio field multiplies the oscillator by 1 to 10, codes above 10 never apply.
// - a new ratio needs 131072 oscillator cycles before the multiplied clock is valid.
// - the core input clock is sent back out as the system clock at the same rate.
// - writes to every control register are dropped unless protected write mode is on.
// - the module also steers entry into and exit from the low-power modes.
// - a ratio of zero bypasses the pll without powering it down.
// - the final divisor is 2 when the halve select bit is 0 and 1 when it is 1.
// - after a non-zero ratio write the clock stays in bypass until lock is reported.
`timescale 1ns/1ps
`include "pllcm_regs.svh"

module pllcm_top
  import pllcm_pkg::*;
#(
  parameter int LOCK_CYCLES = `PLLCM_LOCK_OSC_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic protected_write_mode,
  input wire logic [15:0] watchdog_count_value,
  input wire logic low_power_request,
  input wire logic wake_request,
  input wire logic core_clock_in,
  output logic system_clock_out,
  output logic [3:0] active_ratio,
  output logic pll_bypass,
  output logic pll_locked,
  output logic core_divide_by_two,
  output logic core_clock_enable,
  output logic oscillator_enable,
  output logic [2:0] fast_prescale,
  output logic [2:0] slow_prescale,
  output logic [15:0] clock_gate_0,
  output logic [15:0] clock_gate_1,
  output logic [1:0] lpm_state
);

  // register state
  pllcm_ratio_t ratio_q;
  pllcm_ratio_t ratio_d;
  logic halve_q;
  logic halve_d;
  pllcm_word_t clk_out_q;
  pllcm_word_t clk_out_d;
  pllcm_word_t fast_q;
  pllcm_word_t fast_d;
  pllcm_word_t slow_q;
  pllcm_word_t slow_d;
  pllcm_word_t gate0_q;
  pllcm_word_t gate0_d;
  pllcm_word_t gate1_q;
  pllcm_word_t gate1_d;
  pllcm_word_t lpm_q;
  pllcm_word_t lpm_d;
  pllcm_word_t sys_q;
  pllcm_word_t sys_d;
  pllcm_word_t wdc_q;
  pllcm_word_t wdc_d;
  pllcm_word_t rdata_q;
  pllcm_word_t rdata_d;

  // clock path state
  pllcm_ratio_t act_q;
  pllcm_ratio_t act_d;
  logic bypass_q;
  logic bypass_d;
  logic div2_q;
  logic div2_d;

  // low-power state
  pllcm_lpm_e lp_q;
  pllcm_lpm_e lp_d;

  logic wr_ok;
  logic ratio_write;
  logic ratio_legal;
  logic locked;

  // a write only lands while protected mode is open
  // protected write gate
  assign wr_ok = reg_wr & protected_write_mode;

  assign ratio_legal = reg_wdata[`PLLCM_RATIO_MSB:0] <= `PLLCM_RATIO_MAX;

  assign ratio_write = wr_ok & (reg_addr == `PLLCM_OFF_PLL_MULT) & ratio_legal;

  pllcm_lock_counter #(
    .COUNT_CYCLES(LOCK_CYCLES)
  ) pllcm_lock_counter_inst (
    .clk(clk),
    .rst(rst),
    .start(ratio_write),
    .locked(locked)
  );

  // register writes
  always_comb
  begin
    ratio_d = ratio_q;
    halve_d = halve_q;
    clk_out_d = clk_out_q;
    fast_d = fast_q;
    slow_d = slow_q;
    gate0_d = gate0_q;
    gate1_d = gate1_q;
    lpm_d = lpm_q;
    sys_d = sys_q;
    wdc_d = wdc_q;
    if (ratio_write)
    begin
      ratio_d = reg_wdata[`PLLCM_RATIO_MSB:0];
    end
    if (wr_ok)
    begin
      unique case (reg_addr)
        `PLLCM_OFF_CLK_OUT_STATUS: clk_out_d = reg_wdata;
        `PLLCM_OFF_PLL_STATUS: halve_d = reg_wdata[`PLLCM_STS_HALVE_BIT];
        `PLLCM_OFF_FAST_PRESCALE: fast_d = reg_wdata;
        `PLLCM_OFF_SLOW_PRESCALE: slow_d = reg_wdata;
        `PLLCM_OFF_CLK_GATE_0: gate0_d = reg_wdata;
        `PLLCM_OFF_CLK_GATE_1: gate1_d = reg_wdata;
        `PLLCM_OFF_LOW_POWER: lpm_d = reg_wdata;
        `PLLCM_OFF_SYS_STATUS: sys_d = reg_wdata;
        `PLLCM_OFF_WD_CONTROL: wdc_d = reg_wdata;
        default: ;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ratio_q <= `PLLCM_RST_RATIO;
      halve_q <= 1'b0;
      clk_out_q <= `PLLCM_RST_WORD;
      fast_q <= `PLLCM_RST_WORD;
      slow_q <= `PLLCM_RST_WORD;
      gate0_q <= `PLLCM_RST_WORD;
      gate1_q <= `PLLCM_RST_WORD;
      lpm_q <= `PLLCM_RST_WORD;
      sys_q <= `PLLCM_RST_WORD;
      wdc_q <= `PLLCM_RST_WORD;
    end
    else
    begin
      ratio_q <= ratio_d;
      halve_q <= halve_d;
      clk_out_q <= clk_out_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
      gate0_q <= gate0_d;
      gate1_q <= gate1_d;
      lpm_q <= lpm_d;
      sys_q <= sys_d;
      wdc_q <= wdc_d;
    end
  end

  // read mux, data valid only in the cycle after the strobe
  always_comb
  begin
    rdata_d = `PLLCM_RST_WORD;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `PLLCM_OFF_CLK_OUT_STATUS: rdata_d = clk_out_q;
        `PLLCM_OFF_PLL_STATUS:
        begin
          rdata_d[`PLLCM_STS_LOCK_BIT] = locked;
          rdata_d[`PLLCM_STS_HALVE_BIT] = halve_q;
        end
        `PLLCM_OFF_FAST_PRESCALE: rdata_d = fast_q;
        `PLLCM_OFF_SLOW_PRESCALE: rdata_d = slow_q;
        `PLLCM_OFF_CLK_GATE_0: rdata_d = gate0_q;
        `PLLCM_OFF_CLK_GATE_1: rdata_d = gate1_q;
        `PLLCM_OFF_LOW_POWER: rdata_d = lpm_q;
        `PLLCM_OFF_PLL_MULT: rdata_d[`PLLCM_RATIO_MSB:0] = ratio_q;
        `PLLCM_OFF_SYS_STATUS: rdata_d = sys_q;
        `PLLCM_OFF_WD_COUNT: rdata_d = watchdog_count_value;
        `PLLCM_OFF_WD_CONTROL: rdata_d = wdc_q;
        default: rdata_d = `PLLCM_RST_WORD; // key and holes read zero
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= `PLLCM_RST_WORD;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // clock path selection
  always_comb
  begin
    bypass_d = (ratio_q == `PLLCM_RATIO_BYPASS) | ~locked | ratio_write;
    act_d = bypass_d ? `PLLCM_RATIO_BYPASS : ratio_q;
    div2_d = ~halve_q;
  end

  // clock path flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      act_q <= `PLLCM_RST_RATIO;
      bypass_q <= 1'b1;
      div2_q <= 1'b1;
    end
    else
    begin
      act_q <= act_d;
      bypass_q <= bypass_d;
      div2_q <= div2_d;
    end
  end

  // low-power entry on request, exit on wake
  always_comb
  begin
    lp_d = lp_q;
    unique case (lp_q)
      PLLCM_RUN:
      begin
        if (low_power_request)
        begin
          if (lpm_q[`PLLCM_LPM_MODE_MSB])
          begin
            lp_d = PLLCM_HALT;
          end
          else if (lpm_q[0])
          begin
            lp_d = PLLCM_STANDBY;
          end
          else
          begin
            lp_d = PLLCM_IDLE;
          end
        end
      end
      PLLCM_IDLE, PLLCM_STANDBY, PLLCM_HALT:
      begin
        if (wake_request)
        begin
          lp_d = PLLCM_RUN;
        end
      end
      default: lp_d = PLLCM_RUN;
    endcase
  end

  // low-power state flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lp_q <= PLLCM_RUN;
    end
    else
    begin
      lp_q <= lp_d;
    end
  end

  assign system_clock_out = core_clock_in;

  // outputs
  assign reg_rdata = rdata_q;
  assign active_ratio = act_q;
  assign pll_bypass = bypass_q;
  assign pll_locked = locked;
  assign core_divide_by_two = div2_q;
  assign core_clock_enable = (lp_q == PLLCM_RUN) | (lp_q == PLLCM_IDLE);
  assign oscillator_enable = (lp_q != PLLCM_HALT);
  assign fast_prescale = fast_q[`PLLCM_PRESCALE_MSB:0];
  assign slow_prescale = slow_q[`PLLCM_PRESCALE_MSB:0];
  assign clock_gate_0 = gate0_q;
  assign clock_gate_1 = gate1_q;
  assign lpm_state = lpm_q[`PLLCM_LPM_MODE_MSB:0];

endmodule // pllcm_top

// file: hw/pllcm_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PLLCM_REGS_SVH
`define PLLCM_REGS_SVH

// word offsets on the register port
`define PLLCM_OFF_CLK_OUT_STATUS 16'h7010
`define PLLCM_OFF_PLL_STATUS 16'h7011
`define PLLCM_OFF_FAST_PRESCALE 16'h701A
`define PLLCM_OFF_SLOW_PRESCALE 16'h701B
`define PLLCM_OFF_CLK_GATE_0 16'h701C
`define PLLCM_OFF_CLK_GATE_1 16'h701D
`define PLLCM_OFF_LOW_POWER 16'h701E
`define PLLCM_OFF_PLL_MULT 16'h7021
`define PLLCM_OFF_SYS_STATUS 16'h7022
`define PLLCM_OFF_WD_COUNT 16'h7023
`define PLLCM_OFF_WD_KEY 16'h7025
`define PLLCM_OFF_WD_CONTROL 16'h7029

// field positions
`define PLLCM_STS_LOCK_BIT 0
`define PLLCM_STS_HALVE_BIT 1
`define PLLCM_RATIO_MSB 3
`define PLLCM_LPM_MODE_MSB 1
`define PLLCM_PRESCALE_MSB 2

// ratio limits
`define PLLCM_RATIO_BYPASS 4'h0
`define PLLCM_RATIO_MAX 4'hA

// reset values
`define PLLCM_RST_WORD 16'h0000
`define PLLCM_RST_RATIO 4'h0

// stabilisation time in oscillator cycles
`define PLLCM_LOCK_OSC_CYCLES 131072
`define PLLCM_LOCK_CNT_W 18

`endif

// file: hw/pllcm_pkg.sv
// types shared by the clock module design files
package pllcm_pkg;

  typedef logic [3:0] pllcm_ratio_t;
  typedef logic [15:0] pllcm_word_t;

  // low-power controller states
  typedef enum logic [3:0] {
    PLLCM_RUN = 4'h1,
    PLLCM_IDLE = 4'h2,
    PLLCM_STANDBY = 4'h4,
    PLLCM_HALT = 4'h8
  } pllcm_lpm_e;

endpackage

// file: hw/pllcm_lock_counter.sv
// stabilisation counter restarted by each accepted multiplier write
`timescale 1ns/1ps
`include "pllcm_regs.svh"

module pllcm_lock_counter
  import pllcm_pkg::*;
#(
  parameter int COUNT_CYCLES = `PLLCM_LOCK_OSC_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic locked
);

  logic [`PLLCM_LOCK_CNT_W-1:0] cnt_q;
  logic [`PLLCM_LOCK_CNT_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;

  // load on start, count down, drop busy at zero
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start)
    begin
      cnt_d = `PLLCM_LOCK_CNT_W'(COUNT_CYCLES - 1);
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (cnt_q == '0)
      begin
        busy_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_q - `PLLCM_LOCK_CNT_W'(1);
      end
    end
  end

  // counter registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign locked = ~busy_q;

endmodule // pllcm_lock_counter

// file: verification/pllcm_top_monitor.sv
// assertion checker for the clock module control ports
`timescale 1ns/1ps
`include "pllcm_regs.svh"

module pllcm_top_monitor
  import pllcm_pkg::*;
#(
  parameter int LOCK_CYCLES = `PLLCM_LOCK_OSC_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic protected_write_mode,
  input wire logic core_clock_in,
  input wire logic system_clock_out,
  input wire logic [3:0] active_ratio,
  input wire logic pll_bypass,
  input wire logic pll_locked,
  input wire logic core_clock_enable,
  input wire logic oscillator_enable
);
  logic ratio_wr;
  logic [31:0] wait_d;
  logic [31:0] wait_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // accepted ratio write
  assign ratio_wr = reg_wr && protected_write_mode && reg_addr == `PLLCM_OFF_PLL_MULT
    && reg_wdata[3:0] <= `PLLCM_RATIO_MAX;

  // unlocked cycles since the last accepted write
  always_comb
  begin
    wait_d = wait_q;
    if (ratio_wr)
      wait_d = '0;
    else if (!pll_locked)
      wait_d = wait_q + 32'h1;
  end

  // count register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wait_q <= '0;
    else
      wait_q <= wait_d;
  end

  a_clock_passes_through: assert property (system_clock_out == core_clock_in)
    else $error("system clock out differs from core clock in");
  a_ratio_in_range: assert property (active_ratio <= `PLLCM_RATIO_MAX)
    else $error("active ratio above ten");
  a_bypass_ratio_zero: assert property (pll_bypass |-> active_ratio == 4'h0)
    else $error("ratio applied while bypassed");
  a_unlocked_bypass: assert property (!pll_locked |-> pll_bypass)
    else $error("bypass left before lock");
  a_write_restarts: assert property (ratio_wr |=> !pll_locked && pll_bypass)
    else $error("ratio write did not restart lock");
  a_lock_time: assert property ($rose(pll_locked) |-> wait_q == LOCK_CYCLES)
    else $error("lock came at the wrong time");
  a_guarded_write: assert property (reg_wr && !protected_write_mode && pll_locked |=> pll_locked)
    else $error("unprotected write took effect");
  a_engage_on_lock: assert property ($fell(pll_bypass) |-> $past(pll_locked) && active_ratio != 4'h0)
    else $error("bypass dropped without lock");
  a_halt_stops_core: assert property (!oscillator_enable |-> !core_clock_enable)
    else $error("core clock on with oscillator off");
endmodule // pllcm_top_monitor

bind pllcm_top pllcm_top_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) pllcm_top_monitor_inst (.clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .protected_write_mode, .core_clock_in, .system_clock_out,
  .active_ratio, .pll_bypass, .pll_locked, .core_clock_enable, .oscillator_enable);

// file: verification/pllcm_top_tb_top.sv
// self-checking bench for the clock module control block
`timescale 1ns/1ps

module pllcm_top_tb_top
  import pllcm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic protected_write_mode = 1'b0;
  logic [15:0] watchdog_count_value = 16'h1234;
  logic low_power_request = 1'b0;
  logic wake_request = 1'b0;
  logic core_clock_in = 1'b0;
  logic system_clock_out, pll_bypass, pll_locked, core_divide_by_two;
  logic core_clock_enable, oscillator_enable;
  logic [3:0] active_ratio;
  logic [2:0] fast_prescale, slow_prescale;
  logic [15:0] clock_gate_0, clock_gate_1;
  logic [1:0] lpm_state;
  logic [15:0] st;
  int miscompares = 0;
  int checks = 0;

  // clock and a slower core clock
  always #2.5 clk = ~clk;
  always @(posedge clk) core_clock_in <= ~core_clock_in;

  // status outputs gathered into one word
  assign st = {5'h00, active_ratio, pll_bypass, pll_locked, core_divide_by_two,
    core_clock_enable, oscillator_enable, lpm_state};

  pllcm_top #(.LOCK_CYCLES(16)) pllcm_top_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .protected_write_mode, .watchdog_count_value, .low_power_request,
    .wake_request, .core_clock_in, .system_clock_out, .active_ratio, .pll_bypass, .pll_locked,
    .core_divide_by_two, .core_clock_enable, .oscillator_enable, .fast_prescale,
    .slow_prescale, .clock_gate_0, .clock_gate_1, .lpm_state);

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("read data", reg_rdata, e);
  endtask

  // one low-power request or wake pulse
  task automatic pulse(input bit w);
    @(posedge clk);
    if (w)
      wake_request <= 1'b1;
    else
      low_power_request <= 1'b1;
    @(posedge clk);
    wake_request <= 1'b0;
    low_power_request <= 1'b0;
    @(negedge clk);
  endtask

  // bounded wait for lock, then the switch edge
  task automatic wait_lock;
    int n;
    n = 0;
    // settle past the write edge before looking at lock
    @(negedge clk);
    while (pll_locked !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
    begin
      miscompares++;
      close_out;
    end
    @(posedge clk);
    @(negedge clk);
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset status", st, 16'h007C);
    rd(16'h7011, 16'h0001);
    wr(16'h7021, 16'h0005);
    wr(16'h701A, 16'h0005);
    rd(16'h7021, 16'h0000);
    rd(16'h701A, 16'h0000);
    chk("guarded status", st, 16'h007C);
    @(posedge clk);
    protected_write_mode <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(16'h701A + 16'(i), 16'h0004 + 16'(i));
      rd(16'h701A + 16'(i), 16'h0004 + 16'(i));
    end
    chk("prescalers", {10'h000, fast_prescale, slow_prescale}, 16'h0025);
    chk("gates", {clock_gate_0[7:0], clock_gate_1[7:0]}, 16'h0607);
    rd(16'h7023, 16'h1234);
    rd(16'h7012, 16'h0000);
    wr(16'h7021, 16'h000B);
    @(negedge clk);
    chk("reserved ratio", st, 16'h007C);
    rd(16'h7021, 16'h0000);
    wr(16'h7029, 16'h0001);
    rd(16'h7029, 16'h0001);
    // halve select stays 0 while ratio writes run
    for (int r = 1; r <= 10; r++)
    begin
      wr(16'h7021, 16'(r));
      @(negedge clk);
      chk("settling", st, 16'h005C);
      rd(16'h7011, 16'h0000);
      wait_lock;
      chk("engaged", st, {5'h00, r[3:0], 7'h3C});
      rd(16'h7021, 16'(r));
    end
    wr(16'h7029, 16'h0000);
    rd(16'h7029, 16'h0000);
    // halve select set only after lock
    wr(16'h7011, 16'h0002);
    @(posedge clk);
    @(negedge clk);
    chk("no halving", st, 16'h052C);
    rd(16'h7011, 16'h0003);
    // halve select cleared before the ratio write
    wr(16'h7011, 16'h0000);
    wr(16'h7021, 16'h0000);
    wait_lock;
    chk("bypass", st, 16'h007C);
    repeat (3)
    begin
      @(negedge clk);
      chk("system clock", {15'h0000, system_clock_out}, {15'h0000, core_clock_in});
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(16'h701E, 16'(c));
      pulse(1'b0);
      chk("low power", st, {9'h000, 3'h7, c == 0, c < 2, c[1:0]});
      pulse(1'b1);
      chk("woken", st, {9'h000, 5'h1F, c[1:0]});
    end
    close_out;
  end
endmodule // pllcm_top_tb_top
